// file: jfpc_cmd.sv
`timescale 1ns/1ns
module jfpc_cmd (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_i,
   // Test port pins
   input wire logic tck_i,
   input wire logic tms_i,
   input wire logic tdi_i,
   input wire logic prog_cmd_sel_i,
   output logic tdo_o,
   output logic tdo_oe_o,
   // Status
   output logic busy_o
);
   import jfpc_pkg::*;

   // ****************************************
   // Pin synchronisers
   // ****************************************
   logic [3:0] sync1;
   logic [3:0] sync2;
   logic tck_d;
   logic tck_s;
   logic tms_s;
   logic tdi_s;
   logic sel_s;

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         sync1 <= 4'h0;
         sync2 <= 4'h0;
      end else begin
         sync1 <= {prog_cmd_sel_i, tdi_i, tms_i, tck_i};
         sync2 <= sync1;
      end
   end

   assign tck_s = sync2[0];
   assign tms_s = sync2[1];
   assign tdi_s = sync2[2];
   assign sel_s = sync2[3];

   logic tck_rise;
   logic tck_fall;
   assign tck_rise = tck_s & ~tck_d;
   assign tck_fall = ~tck_s & tck_d;

   // ****************************************
   // Test port state and command register
   // ****************************************
   jfpc_tap_type tap, next_tap;
   logic [CMD_W-1:0] sr, next_sr;
   logic [CMD_W-1:0] cmd, next_cmd;
   logic pending, next_pending;
   logic exec_q, next_exec;
   logic tdo_q, next_tdo;
   logic tdo_oe_q, next_tdo_oe;
   logic [CMD_W-1:0] result;
   logic [CMD_W-1:0] capture_word;
   logic busy;

   // Status is live at capture so a poll never sees a stale bit
   always_comb begin
      capture_word = result;
      capture_word[STATUS_BIT] = ~busy;
   end

   always_comb begin
      next_tap = tap;
      next_sr = sr;
      next_cmd = cmd;
      next_pending = pending;
      next_exec = 1'b0;
      next_tdo = tdo_q;
      next_tdo_oe = tdo_oe_q;
      if (tck_rise) begin
         case (tap)
            TAP_TLR: next_tap = tms_s ? TAP_TLR : TAP_RTI;
            TAP_RTI: next_tap = tms_s ? TAP_SELDR : TAP_RTI;
            TAP_SELDR: next_tap = tms_s ? TAP_SELIR : TAP_CAPDR;
            TAP_CAPDR: next_tap = tms_s ? TAP_EX1DR : TAP_SHDR;
            TAP_SHDR: next_tap = tms_s ? TAP_EX1DR : TAP_SHDR;
            TAP_EX1DR: next_tap = tms_s ? TAP_UPDDR : TAP_PAUDR;
            TAP_PAUDR: next_tap = tms_s ? TAP_EX2DR : TAP_PAUDR;
            TAP_EX2DR: next_tap = tms_s ? TAP_UPDDR : TAP_SHDR;
            TAP_UPDDR: next_tap = tms_s ? TAP_SELDR : TAP_RTI;
            TAP_SELIR: next_tap = tms_s ? TAP_TLR : TAP_CAPIR;
            TAP_CAPIR: next_tap = tms_s ? TAP_EX1IR : TAP_SHIR;
            TAP_SHIR: next_tap = tms_s ? TAP_EX1IR : TAP_SHIR;
            TAP_EX1IR: next_tap = tms_s ? TAP_UPDIR : TAP_PAUIR;
            TAP_PAUIR: next_tap = tms_s ? TAP_EX2IR : TAP_PAUIR;
            TAP_EX2IR: next_tap = tms_s ? TAP_UPDIR : TAP_SHIR;
            TAP_UPDIR: next_tap = tms_s ? TAP_SELDR : TAP_RTI;
            default: next_tap = TAP_TLR;
         endcase
         if (sel_s) begin
            if (tap == TAP_CAPDR) begin
               next_sr = capture_word;
            end else if (tap == TAP_SHDR) begin
               next_sr = {tdi_s, sr[CMD_W-1:1]};
            end else if (tap == TAP_UPDDR) begin
               next_cmd = sr;
               next_pending = 1'b1;
            end
         end
         // One execution clock per applied command
         if (tap == TAP_RTI && pending) begin
            next_exec = 1'b1;
            next_pending = 1'b0;
         end
      end
      if (tck_fall) begin
         next_tdo = sr[0];
         next_tdo_oe = sel_s && (tap == TAP_SHDR);
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         tck_d <= 1'b0;
         tap <= TAP_TLR;
         sr <= CMD_RESET;
         cmd <= CMD_RESET;
         pending <= 1'b0;
         exec_q <= 1'b0;
         tdo_q <= 1'b0;
         tdo_oe_q <= 1'b0;
      end else begin
         tck_d <= tck_s;
         tap <= next_tap;
         sr <= next_sr;
         cmd <= next_cmd;
         pending <= next_pending;
         exec_q <= next_exec;
         tdo_q <= next_tdo;
         tdo_oe_q <= next_tdo_oe;
      end
   end

   assign tdo_o = tdo_q;
   assign tdo_oe_o = tdo_oe_q;

   // ****************************************
   // Flash storage
   // ****************************************
   logic buf_we;
   logic [DATA_W-1:0] buf_rdata;
   logic flash_we;
   logic [FLASH_AW-1:0] flash_waddr;
   logic [DATA_W-1:0] flash_wdata;
   logic [DATA_W-1:0] flash_rdata;
   logic [ARG_W-1:0] addr_hi, next_addr_hi;
   logic [ARG_W-1:0] addr_lo, next_addr_lo;
   logic [EXT_W-1:0] addr_ext, next_addr_ext;
   logic [ARG_W-1:0] data_lo, next_data_lo;
   logic [ARG_W-1:0] data_hi, next_data_hi;
   logic [CNT_W-1:0] cnt, next_cnt;

   jfpc_mem #(.WIDTH(DATA_W), .DEPTH(PAGE_DEPTH), .AW(PAGE_AW)) u_page (
      .clk_sys_i(clk_sys_i),
      .we_i(buf_we),
      .waddr_i(addr_lo[PAGE_AW-1:0]),
      .wdata_i({data_hi, data_lo}),
      .raddr_i(cnt[PAGE_AW-1:0]),
      .rdata_o(buf_rdata)
   );

   jfpc_mem #(.WIDTH(DATA_W), .DEPTH(FLASH_DEPTH), .AW(FLASH_AW)) u_flash (
      .clk_sys_i(clk_sys_i),
      .we_i(flash_we),
      .waddr_i(flash_waddr),
      .wdata_i(flash_wdata),
      .raddr_i({addr_hi, addr_lo}),
      .rdata_o(flash_rdata)
   );

   // ****************************************
   // Command engine
   // ****************************************
   jfpc_mode_type mode, next_mode;
   jfpc_eng_type eng, next_eng;
   logic [CMD_W-1:0] next_result;
   logic [DATA_W-1:0] read_word, next_read_word;
   logic next_busy;
   logic busy_q;
   logic [PFX_W-1:0] pfx;
   logic [ARG_W-1:0] arg;
   logic addr_ok;

   assign pfx = cmd[CMD_W-1:ARG_W];
   assign arg = cmd[ARG_W-1:0];
   // Addresses beyond the array are refused rather than aliased
   assign addr_ok = (addr_ext == EXT_VALID);
   assign busy = (eng != ENG_IDLE);

   always_comb begin
      next_mode = mode;
      next_eng = eng;
      next_result = result;
      next_read_word = read_word;
      next_addr_hi = addr_hi;
      next_addr_lo = addr_lo;
      next_addr_ext = addr_ext;
      next_data_lo = data_lo;
      next_data_hi = data_hi;
      next_cnt = cnt;
      buf_we = 1'b0;
      flash_we = 1'b0;
      flash_waddr = cnt[FLASH_AW-1:0];
      flash_wdata = ERASED_WORD;
      if (exec_q) begin
         case (pfx)
            PFX_MODE: begin
               if (arg == ARG_ERASE) begin
                  next_mode = MODE_ERASE;
               end else if (arg == ARG_WRITE) begin
                  next_mode = MODE_WRITE;
               end else if (arg == ARG_READ) begin
                  next_mode = MODE_READ;
               end
            end
            PFX_ADDR_EXT: next_addr_ext = arg[EXT_W-1:0];
            PFX_ADDR_HI: next_addr_hi = arg;
            PFX_ADDR_LO: next_addr_lo = arg;
            PFX_DATA_LO: next_data_lo = arg;
            PFX_DATA_HI: next_data_hi = arg;
            PFX_LATCH: buf_we = (mode == MODE_WRITE);
            PFX_ERASE_GO: begin
               if (mode == MODE_ERASE && !busy) begin
                  next_eng = ENG_ERASE;
                  next_cnt = '0;
               end
            end
            PFX_PAGE_GO: begin
               if (mode == MODE_WRITE && !busy && addr_ok) begin
                  next_eng = ENG_PAGE;
                  next_cnt = '0;
               end
            end
            PFX_READ_GO: begin
               if (mode == MODE_READ && !busy) begin
                  next_eng = ENG_RD1;
               end
            end
            PFX_READ_HI: begin
               next_result = {{(CMD_W-ARG_W){1'b0}}, read_word[DATA_W-1:ARG_W]};
            end
            default: begin
            end
         endcase
      end
      case (eng)
         ENG_IDLE: begin
         end
         ENG_ERASE: begin
            flash_we = 1'b1;
            next_cnt = CNT_W'(cnt + 1'b1);
            if (cnt == ERASE_LAST_CNT) begin
               next_eng = ENG_IDLE;
            end
         end
         ENG_PAGE: begin
            // Buffer read data lag the index by one cycle
            next_cnt = CNT_W'(cnt + 1'b1);
            flash_we = (cnt != '0);
            flash_waddr = {addr_hi, addr_lo[ARG_W-1], PAGE_AW'(cnt[PAGE_AW-1:0] - 1'b1)};
            flash_wdata = buf_rdata;
            if (cnt == PAGE_LAST_CNT) begin
               next_eng = ENG_IDLE;
            end
         end
         ENG_RD1: next_eng = ENG_RD2;
         ENG_RD2: begin
            next_read_word = addr_ok ? flash_rdata : ERASED_WORD;
            next_result = {{(CMD_W-ARG_W){1'b0}}, next_read_word[ARG_W-1:0]};
            next_eng = ENG_IDLE;
         end
         default: next_eng = ENG_IDLE;
      endcase
      next_busy = (next_eng != ENG_IDLE);
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         mode <= MODE_NONE;
         eng <= ENG_IDLE;
         result <= CMD_RESET;
         read_word <= ERASED_WORD;
         addr_hi <= 8'h00;
         addr_lo <= 8'h00;
         addr_ext <= EXT_VALID;
         data_lo <= 8'hff;
         data_hi <= 8'hff;
         cnt <= '0;
         busy_q <= 1'b0;
      end else begin
         mode <= next_mode;
         eng <= next_eng;
         result <= next_result;
         read_word <= next_read_word;
         addr_hi <= next_addr_hi;
         addr_lo <= next_addr_lo;
         addr_ext <= next_addr_ext;
         data_lo <= next_data_lo;
         data_hi <= next_data_hi;
         cnt <= next_cnt;
         busy_q <= next_busy;
      end
   end

   assign busy_o = busy_q;

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (rst_i);

   a_tdo_enable: assert property (tck_fall && sel_s && tap == TAP_SHDR |=> tdo_oe_o)
      else $error("tdo enable missing in shift");
   a_shift_lsb: assert property (tck_rise && sel_s && tap == TAP_SHDR
      |=> sr[CMD_W-1] == $past(tdi_s) && sr[CMD_W-2:0] == $past(sr[CMD_W-1:1]))
      else $error("shift not lsb first");
   a_capture_load: assert property (tck_rise && sel_s && tap == TAP_CAPDR
      |=> sr == $past(capture_word))
      else $error("capture did not load result");
   // The programmer may leave idle on the very rise that executes
   a_exec_idle: assert property (exec_q |-> $past(tap) == TAP_RTI && $past(tck_rise))
      else $error("execution outside idle");
   a_exec_single: assert property (exec_q |=> !exec_q [*5])
      else $error("command executed twice");
   a_write_mode: assert property (exec_q && pfx == PFX_MODE && arg == ARG_WRITE
      |=> mode == MODE_WRITE)
      else $error("write mode not entered");
   a_read_mode: assert property (exec_q && pfx == PFX_MODE && arg == ARG_READ
      |=> mode == MODE_READ)
      else $error("read mode not entered");
   a_addr_load: assert property (exec_q && pfx == PFX_ADDR_LO
      |=> addr_lo == $past(arg) && addr_hi == $past(addr_hi))
      else $error("address low byte not loaded");
   a_addr_high: assert property (exec_q && pfx == PFX_ADDR_HI |=> addr_hi == $past(arg))
      else $error("address high byte not loaded");
   a_addr_ext: assert property (exec_q && pfx == PFX_ADDR_EXT
      |=> addr_ext == $past(arg[EXT_W-1:0]))
      else $error("extended address not loaded");
   a_latch_write: assert property (exec_q && pfx == PFX_LATCH && mode == MODE_WRITE
      |-> buf_we)
      else $error("latch did not store data");
   a_page_busy: assert property (exec_q && pfx == PFX_PAGE_GO
      && mode == MODE_WRITE && !busy && addr_ok |=> busy ##129 !busy)
      else $error("page write length wrong");
   a_read_low: assert property (eng == ENG_RD1 ##1 addr_ok
      |=> result[ARG_W-1:0] == $past(flash_rdata[ARG_W-1:0]) && !busy)
      else $error("read low byte wrong");

   c_erase: cover property (exec_q && pfx == PFX_ERASE_GO && mode == MODE_ERASE);
   c_page_done: cover property (eng == ENG_PAGE ##1 eng == ENG_IDLE);
   c_read_done: cover property (eng == ENG_RD2);

endmodule

// file: jfpc_pkg.sv
package jfpc_pkg;

   // ****************************************
   // Widths and depths
   // ****************************************
   localparam int CMD_W = 15;
   localparam int PFX_W = 7;
   localparam int ARG_W = 8;
   localparam int EXT_W = 7;
   localparam int DATA_W = 16;
   localparam int FLASH_AW = 16;
   localparam int FLASH_DEPTH = 65536;
   localparam int PAGE_AW = 7;
   localparam int PAGE_DEPTH = 128;
   localparam int CNT_W = 17;
   localparam int STATUS_BIT = 9;

   // ****************************************
   // Command prefixes (upper seven bits)
   // ****************************************
   localparam logic [PFX_W-1:0] PFX_MODE = 7'h23;
   localparam logic [PFX_W-1:0] PFX_ERASE_GO = 7'h31;
   localparam logic [PFX_W-1:0] PFX_ERASE_POLL = 7'h33;
   localparam logic [PFX_W-1:0] PFX_ADDR_EXT = 7'h0b;
   localparam logic [PFX_W-1:0] PFX_ADDR_HI = 7'h07;
   localparam logic [PFX_W-1:0] PFX_ADDR_LO = 7'h03;
   localparam logic [PFX_W-1:0] PFX_DATA_LO = 7'h13;
   localparam logic [PFX_W-1:0] PFX_DATA_HI = 7'h17;
   localparam logic [PFX_W-1:0] PFX_LATCH = 7'h77;
   localparam logic [PFX_W-1:0] PFX_PAGE_POLL = 7'h37;
   localparam logic [PFX_W-1:0] PFX_PAGE_GO = 7'h35;
   localparam logic [PFX_W-1:0] PFX_READ_GO = 7'h32;
   localparam logic [PFX_W-1:0] PFX_READ_HI = 7'h36;

   // ****************************************
   // Mode arguments (lower eight bits)
   // ****************************************
   localparam logic [ARG_W-1:0] ARG_ERASE = 8'h80;
   localparam logic [ARG_W-1:0] ARG_WRITE = 8'h10;
   localparam logic [ARG_W-1:0] ARG_READ = 8'h02;

   // ****************************************
   // Values and counts
   // ****************************************
   localparam logic [DATA_W-1:0] ERASED_WORD = 16'hffff;
   localparam logic [CMD_W-1:0] CMD_RESET = 15'h0000;
   localparam logic [CNT_W-1:0] PAGE_LAST_CNT = 17'h00080;
   localparam logic [CNT_W-1:0] ERASE_LAST_CNT = 17'h0ffff;
   localparam logic [EXT_W-1:0] EXT_VALID = 7'h00;

   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [3:0] {
      TAP_EX2DR = 4'b0000,
      TAP_EX1DR = 4'b0001,
      TAP_SHDR = 4'b0010,
      TAP_PAUDR = 4'b0011,
      TAP_SELIR = 4'b0100,
      TAP_UPDDR = 4'b0101,
      TAP_CAPDR = 4'b0110,
      TAP_SELDR = 4'b0111,
      TAP_EX2IR = 4'b1000,
      TAP_EX1IR = 4'b1001,
      TAP_SHIR = 4'b1010,
      TAP_PAUIR = 4'b1011,
      TAP_RTI = 4'b1100,
      TAP_UPDIR = 4'b1101,
      TAP_CAPIR = 4'b1110,
      TAP_TLR = 4'b1111
   } jfpc_tap_type;

   typedef enum logic [1:0] {
      MODE_NONE = 2'b00,
      MODE_ERASE = 2'b01,
      MODE_WRITE = 2'b10,
      MODE_READ = 2'b11
   } jfpc_mode_type;

   typedef enum logic [2:0] {
      ENG_IDLE = 3'b000,
      ENG_ERASE = 3'b001,
      ENG_PAGE = 3'b010,
      ENG_RD1 = 3'b011,
      ENG_RD2 = 3'b100
   } jfpc_eng_type;

endpackage

// file: jfpc_mem.sv
`timescale 1ns/1ns
module jfpc_mem #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 128,
   parameter int AW = 7
) (
   // Clock
   input wire logic clk_sys_i,
   // Write port
   input wire logic we_i,
   input wire logic [AW-1:0] waddr_i,
   input wire logic [WIDTH-1:0] wdata_i,
   // Read port
   input wire logic [AW-1:0] raddr_i,
   output logic [WIDTH-1:0] rdata_o
);

   logic [WIDTH-1:0] mem [DEPTH];

   // Registered read, one cycle after the address
   always_ff @(posedge clk_sys_i) begin
      if (we_i) begin
         mem[waddr_i] <= wdata_i;
      end
      rdata_o <= mem[raddr_i];
   end

endmodule

// file: jfpc_prog_model.sv
`timescale 1ns/1ns
// ****************************************
// Programmer on the far side of the test port
// ****************************************
module jfpc_prog_model #(
   parameter int HALF_NS = 160
) (
   // Link pins towards the device
   output logic tck_o,
   output logic tms_o,
   output logic tdi_o,
   // Link pins from the device
   input wire logic tdo_i,
   input wire logic tdo_oe_i
);
   import jfpc_pkg::*;

   initial begin
      tck_o = 1'b0;
      tms_o = 1'b1;
      tdi_o = 1'b0;
   end

   // One test clock period; the clock stands still low between frames
   task automatic tick(input logic m, input logic d, output logic q, output logic oe);
      tms_o = m;
      tdi_o = d;
      #(HALF_NS);
      tck_o = 1'b1;
      // Sample late in the high phase, since tdo only moves a few clocks after the fall
      #(HALF_NS - 10);
      // A released line reads as the inverse, so an undriven bit never passes
      q = tdo_oe_i ? tdo_i : ~tdo_i;
      oe = tdo_oe_i;
      #10;
      tck_o = 1'b0;
   endtask

   // Walk to run-test idle; a released data line toggles so it never looks driven
   task automatic go_idle();
      logic q;
      logic oe;
      for (int i = 0; i < 5; i++) begin
         tick(1'b1, ~tdi_o, q, oe);
      end
      tick(1'b0, ~tdi_o, q, oe);
   endtask

   // One command frame from idle back to idle
   task automatic shift_cmd(input logic [CMD_W-1:0] cmd, input int idle,
         output logic [CMD_W-1:0] res, output logic [4:0] oe_cnt);
      logic q;
      logic oe;
      oe_cnt = 5'h00;
      res = 15'h0000;
      tick(1'b1, ~tdi_o, q, oe);
      tick(1'b0, ~tdi_o, q, oe);
      tick(1'b0, ~tdi_o, q, oe);
      for (int i = 0; i < CMD_W; i++) begin
         tick(i == CMD_W - 1, cmd[i], q, oe);
         res[i] = q;
         oe_cnt = oe_cnt + {4'h0, oe};
      end
      tick(1'b1, ~tdi_o, q, oe);
      tick(1'b0, ~tdi_o, q, oe);
      // Extra idle rises model a slow programmer; the command still runs once
      for (int i = 0; i <= idle; i++) begin
         tick(1'b0, ~tdi_o, q, oe);
      end
   endtask
endmodule

// file: jfpc_cmd_bench.sv
`timescale 1ns/1ns
module jfpc_cmd_bench;
   import jfpc_pkg::*;

   // ****************************************
   // Signals
   // ****************************************
   logic clk_sys_i;
   logic rst_i;
   logic tck;
   logic tms;
   logic tdi;
   logic sel;
   logic tdo;
   logic tdo_oe;
   logic busy;
   int n_fail;
   int n_tests;
   logic [CMD_W-1:0] res;
   logic [4:0] oe_cnt;
   localparam logic [15:0] WDAT [2] = '{16'h5a3c, 16'hc381};
   localparam logic [7:0] WLO [2] = '{8'h05, 8'h7e};

   always #20 clk_sys_i = ~clk_sys_i;

   jfpc_cmd jfpc_cmd_i (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .tck_i(tck),
      .tms_i(tms),
      .tdi_i(tdi),
      .prog_cmd_sel_i(sel),
      .tdo_o(tdo),
      .tdo_oe_o(tdo_oe),
      .busy_o(busy)
   );

   jfpc_prog_model jfpc_prog_model_i (
      .tck_o(tck),
      .tms_o(tms),
      .tdi_o(tdi),
      .tdo_i(tdo),
      .tdo_oe_i(tdo_oe)
   );

   // ****************************************
   // Reporting and compares
   // ****************************************
   task automatic report_and_stop();
      if (n_fail == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic chk1(input logic got, input logic exp, input string what);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t: %s got %b expected %b", $time, what, got, exp);
      end
   endtask

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // ****************************************
   // Frame helpers
   // ****************************************
   task automatic send(input logic [PFX_W-1:0] pfx, input logic [ARG_W-1:0] arg,
         input int idle = 0);
      jfpc_prog_model_i.shift_cmd({pfx, arg}, idle, res, oe_cnt);
      chk8({3'h0, oe_cnt}, sel ? 8'h0f : 8'h00, "shift length");
   endtask

   // Bounded poll; a hang shows up as a missing completion
   task automatic poll(input logic [PFX_W-1:0] pfx, input logic [ARG_W-1:0] arg, input int limit);
      int k;
      k = 0;
      send(pfx, arg);
      while (res[STATUS_BIT] !== 1'b1 && k < limit) begin
         send(pfx, arg);
         k++;
      end
      chk1(res[STATUS_BIT], 1'b1, "completion status");
      chk1(busy, 1'b0, "busy after completion");
   endtask

   task automatic read_word(input logic [7:0] hi, input logic [7:0] lo, input logic [15:0] exp);
      send(PFX_ADDR_HI, hi);
      send(PFX_ADDR_LO, lo);
      send(PFX_READ_GO, 8'h00, 2);
      send(PFX_READ_HI, 8'h00);
      chk8(res[7:0], exp[7:0], "read low byte");
      send(PFX_PAGE_POLL, 8'h00);
      chk8(res[7:0], exp[15:8], "read high byte");
   endtask

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_reset();
      chk1(tdo, 1'b0, "tdo after reset");
      chk1(tdo_oe, 1'b0, "tdo enable after reset");
      chk1(busy, 1'b0, "busy after reset");
      jfpc_prog_model_i.go_idle();
      // Without the instruction the register must not reach the pins
      send(PFX_MODE, ARG_READ);
      @(posedge clk_sys_i);
      #2 sel = 1'b1;
   endtask

   task automatic t_erase();
      send(PFX_MODE, ARG_ERASE);
      send(PFX_ERASE_GO, ARG_ERASE);
      chk1(busy, 1'b1, "erase busy");
      send(PFX_ERASE_POLL, ARG_ERASE);
      chk1(res[STATUS_BIT], 1'b0, "erase in progress");
      send(PFX_ERASE_POLL, ARG_ERASE);
      poll(PFX_ERASE_POLL, ARG_ERASE, 600);
   endtask

   task automatic t_write();
      send(PFX_MODE, ARG_WRITE);
      send(PFX_ADDR_EXT, 8'h00);
      send(PFX_ADDR_HI, 8'h12);
      for (int w = 0; w < 2; w++) begin
         send(PFX_ADDR_LO, WLO[w]);
         send(PFX_DATA_LO, WDAT[w][7:0]);
         send(PFX_DATA_HI, WDAT[w][15:8]);
         send(PFX_PAGE_POLL, 8'h00);
         send(PFX_LATCH, 8'h00, 2);
         send(PFX_PAGE_POLL, 8'h00);
      end
      send(PFX_PAGE_POLL, 8'h00);
      send(PFX_PAGE_GO, 8'h00);
      chk1(busy, 1'b1, "page write busy");
      send(PFX_PAGE_POLL, 8'h00);
      chk1(res[STATUS_BIT], 1'b0, "page write in progress");
      poll(PFX_PAGE_POLL, 8'h00, 10);
   endtask

   task automatic t_read();
      send(PFX_MODE, ARG_READ);
      // A non-zero extended part points outside the array
      send(PFX_ADDR_EXT, 8'h01);
      read_word(8'h12, WLO[0], ERASED_WORD);
      send(PFX_ADDR_EXT, 8'h00);
      read_word(8'h12, WLO[0], WDAT[0]);
      read_word(8'h12, WLO[1], WDAT[1]);
      read_word(8'h13, WLO[0], ERASED_WORD);
   endtask

   // ****************************************
   // Main sequence and watchdog
   // ****************************************
   initial begin
      clk_sys_i = 1'b0;
      rst_i = 1'b1;
      sel = 1'b0;
      n_fail = 0;
      n_tests = 0;
      repeat (12) @(posedge clk_sys_i);
      #2 rst_i = 1'b0;
      @(posedge clk_sys_i);
      #2;
      t_reset();
      t_erase();
      t_write();
      t_read();
      report_and_stop();
   end

   // Erase alone needs about 2.6 ms; the other frames add a few hundred microseconds
   initial begin
      #3800000;
      n_fail++;
      report_and_stop();
   end
endmodule
